/* uart_irq_pkg.sv */
// constants and carrier types for the uart interrupt/status block
// assumes one clock domain shared with the uart datapath
package uart_irq_pkg;
  // register addresses on a2..a0
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_ISR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  localparam logic [2:0] A_SPR  = 3'h7;
  // bank select value and bit positions
  localparam logic [7:0] LCR_ENH_BANK = 8'hbf;
  localparam int         LCR_DIV_BIT  = 7;
  localparam int         EFR_ENH_BIT  = 4;
  localparam int         EFR_ARTS_BIT = 6;
  localparam int         EFR_ACTS_BIT = 7;
  // reset values
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [3:0] MODEM_RST = 4'hf;
  // status codes, bits 5:0
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_LSR  = 6'h06;
  localparam logic [5:0] ISR_TOUT = 6'h0c;
  localparam logic [5:0] ISR_RXD  = 6'h04;
  localparam logic [5:0] ISR_THR  = 6'h02;
  localparam logic [5:0] ISR_MSR  = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  // fifo trigger levels
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  // receive timeout: characters plus extra bit times
  localparam logic [6:0] TOUT_CHARS = 7'h04;
  localparam logic [6:0] TOUT_BITS  = 7'h0c;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic [4:0] level;     // characters in receive fifo
    logic       char_in;   // character moved into fifo
    logic       overrun;   // overrun on reception
    logic [2:0] head_err;  // {break, framing, parity} of head byte
    logic       fifo_err;  // error anywhere in fifo
    logic [7:0] data;      // head byte
  } rx_stat_s;

  typedef struct packed {
    logic [4:0] level;
    logic       shift_empty;
  } tx_stat_s;

  typedef struct packed {
    logic xoff;     // pause character(s) matched
    logic xon;      // resume character(s) matched
    logic special;  // special character matched
    logic rts_n;    // local rts# output level
  } flow_evt_s;

  typedef struct packed {
    logic       fifo_en;
    logic       dma_mode;
    logic [1:0] rx_trig;
    logic [7:0] line_control_reg;
    logic [4:0] mcr_lo;
    logic [7:0] enhanced_feature_control;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
  } cfg_s;

  typedef struct packed {
    logic       sleep_en;
    logic [1:0] tx_trig;
    logic [2:0] mcr_hi;
    logic [5:0] divisor_fraction_reg;
  } ext_s;
endpackage

/* uart_interrupt_enable_status.sv */
// interrupt enable, priority, status and clear logic of one uart channel
// assumes the datapath (fifos, framing, flow control) shares ref_clk
// Summary of operation
// - extended bits act only with enhanced enable
// - rx data irq at trigger, drops below
// - data ready set on entry, clear empty
// - polled mode via line status bits
// - line status bit layout
// - enable bit 0 gates rx data irq
// - enable bit 1 gates tx ready irq
// - overrun at once, errors at read-out
// - enable bit 3 gates modem deltas
// - sleep and xoff enables need enhanced
// - bits 6,7 enable rts/cts rise irqs
// - status read gives highest pending source
// - fixed six-bit priority codes
// - timeout four chars plus twelve bits
// - tx ready cleared by status read/write
// - line status read clears, rx by level
// - modem read clears modem, flow irqs
// - xoff/special clear rules
// - cts/rts rise only in auto flow
// - status bit 0 low when pending
// - status bit 4 xoff/special match
// - status bits 7:6 show fifo enable
// - rx trigger 1,4,8,14, default 1
`timescale 1ns/10ps
`default_nettype none
module uart_interrupt_enable_status (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // host register port
  input  wire uart_irq_pkg::host_req_s host_req,
  output logic [7:0]                  rd_data_reg,
  // datapath status
  input  wire uart_irq_pkg::rx_stat_s rx_stat,
  input  wire uart_irq_pkg::tx_stat_s tx_stat,
  input  wire logic                   bit_tick,
  input  wire uart_irq_pkg::flow_evt_s flow_evt,
  // modem pins {cd#, ri#, dsr#, cts#}
  input  wire logic [3:0]             modem_n,
  // datapath strobes
  output logic                        rhr_pop_reg,
  output logic                        thr_push_reg,
  output logic [7:0]                  thr_data_reg,
  output logic                        rx_fifo_clear_reg,
  output logic                        tx_fifo_clear_reg,
  // configuration
  output uart_irq_pkg::cfg_s          cfg_reg,
  output uart_irq_pkg::ext_s          ext_reg,
  // interrupt
  output logic                        irq_reg
);
  logic       rd, wr, enh_bank, div_bank, efr4;
  logic       rd_rhr, rd_isr, rd_lsr, rd_msr;
  logic       wr_thr, wr_ier, wr_fcr, wr_efr, wr_dld, wr_lcr, wr_mcr;
  logic       wr_chr, wr_spr;
  logic [7:0] ier_reg, ier_eff, spr_reg, rd_mux;
  logic [1:0] tx_trig_reg;
  logic [2:0] mcr_hi_reg;
  logic [5:0] dld_reg;
  logic [5:0] code;
  logic [7:1] pend;
  logic       rx_cond, tx_cond, tx_cond_d_reg, thr_flag_reg;
  logic       ovr_flag_reg, nonempty_d_reg, head_new;
  logic [2:0] err_reg;
  logic [6:0] char_bits, tout_limit, tout_cnt_reg;
  logic       tout_flag_reg, tout_hit;
  logic [3:0] m1_reg, m2_reg, m3_reg, mst_reg, chg, delta_reg;
  logic       rts_d_reg, cts_rise, rts_rise, flow_flag_reg;
  logic       xoff_flag_reg, spec_flag_reg;

  function automatic logic [4:0] trig_lvl(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_lvl = uart_irq_pkg::TRIG_L0;
      2'h1:    trig_lvl = uart_irq_pkg::TRIG_L1;
      2'h2:    trig_lvl = uart_irq_pkg::TRIG_L2;
      default: trig_lvl = uart_irq_pkg::TRIG_L3;
    endcase
  endfunction

  // address decode, bank chosen by the line control value
  assign rd       = host_req.cs & host_req.rd;
  assign wr       = host_req.cs & host_req.wr;
  assign enh_bank = cfg_reg.line_control_reg == uart_irq_pkg::LCR_ENH_BANK;
  assign div_bank = cfg_reg.line_control_reg[uart_irq_pkg::LCR_DIV_BIT] & ~enh_bank;
  assign efr4     = cfg_reg.enhanced_feature_control[uart_irq_pkg::EFR_ENH_BIT];
  assign rd_rhr = rd & ~cfg_reg.line_control_reg[7] & host_req.addr == uart_irq_pkg::A_DATA;
  assign wr_thr = wr & ~cfg_reg.line_control_reg[7] & host_req.addr == uart_irq_pkg::A_DATA;
  assign rd_isr = rd & ~enh_bank & ~(div_bank & efr4)
                  & host_req.addr == uart_irq_pkg::A_ISR;
  assign rd_lsr = rd & ~enh_bank & host_req.addr == uart_irq_pkg::A_LSR;
  assign rd_msr = rd & ~enh_bank & host_req.addr == uart_irq_pkg::A_MSR;
  assign wr_ier = wr & ~cfg_reg.line_control_reg[7] & host_req.addr == uart_irq_pkg::A_IER;
  assign wr_fcr = wr & ~cfg_reg.line_control_reg[7] & host_req.addr == uart_irq_pkg::A_ISR;
  assign wr_efr = wr & enh_bank & host_req.addr == uart_irq_pkg::A_ISR;
  assign wr_dld = wr & div_bank & efr4 & host_req.addr == uart_irq_pkg::A_ISR;
  assign wr_lcr = wr & host_req.addr == uart_irq_pkg::A_LCR;
  assign wr_mcr = wr & ~enh_bank & host_req.addr == uart_irq_pkg::A_MCR;
  assign wr_spr = wr & ~enh_bank & host_req.addr == uart_irq_pkg::A_SPR;
  assign wr_chr = wr & enh_bank & host_req.addr[2];

  // base configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg <= '0;
    end else begin
      if (wr_lcr) cfg_reg.line_control_reg <= host_req.wdata;
      if (wr_efr) cfg_reg.enhanced_feature_control <= host_req.wdata;
      if (wr_mcr) cfg_reg.mcr_lo <= host_req.wdata[4:0];
      if (wr_fcr) begin
        cfg_reg.fifo_en <= host_req.wdata[0];
        if (host_req.wdata[0]) begin  // other bits need enable set
          cfg_reg.dma_mode <= host_req.wdata[3];
          cfg_reg.rx_trig  <= host_req.wdata[7:6];
        end
      end
      if (wr_chr) begin
        case (host_req.addr[1:0])
          2'h0:    cfg_reg.resume_char_first  <= host_req.wdata;
          2'h1:    cfg_reg.resume_char_second <= host_req.wdata;
          2'h2:    cfg_reg.pause_char_first   <= host_req.wdata;
          default: cfg_reg.pause_char_second  <= host_req.wdata;
        endcase
      end
    end
  end

  // extended fields, writable only with enhanced enable; scratch register writable outside the enhanced bank
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_trig_reg <= 2'h0;
      mcr_hi_reg  <= 3'h0;
      dld_reg     <= 6'h00;
      spr_reg     <= uart_irq_pkg::REG_RST;
    end else begin
      if (wr_fcr && host_req.wdata[0] && efr4)
        tx_trig_reg <= host_req.wdata[5:4];
      if (wr_mcr && efr4) mcr_hi_reg <= host_req.wdata[7:5];
      if (wr_dld) dld_reg <= host_req.wdata[5:0];
      if (wr_spr) spr_reg <= host_req.wdata;
    end
  end

  // extended outputs forced inactive without enhanced enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_reg <= '0;
    end else begin
      ext_reg.sleep_en <= ier_eff[4];
      ext_reg.tx_trig  <= efr4 ? tx_trig_reg : 2'h0;
      ext_reg.mcr_hi   <= efr4 ? mcr_hi_reg : 3'h0;
      ext_reg.divisor_fraction_reg      <= efr4 ? dld_reg : 6'h00;
    end
  end

  // interrupt enable register, upper nibble guarded
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ier_reg <= uart_irq_pkg::REG_RST;
    end else if (wr_ier) begin
      ier_reg <= efr4 ? host_req.wdata
                      : {ier_reg[7:4], host_req.wdata[3:0]};
    end
  end
  assign ier_eff = efr4 ? ier_reg : {4'h0, ier_reg[3:0]};

  // receive data condition: trigger level or holding full
  assign rx_cond = cfg_reg.fifo_en
                   ? rx_stat.level >= trig_lvl(cfg_reg.rx_trig)
                   : rx_stat.level != 5'h00;
  // transmit ready: below trigger, or holding empty
  assign tx_cond = cfg_reg.fifo_en
                   ? rx_lt_tx(tx_stat.level, ext_reg.tx_trig)
                   : tx_stat.level == 5'h00;
  function automatic logic rx_lt_tx(input logic [4:0] lvl,
                                    input logic [1:0] sel);
    rx_lt_tx = lvl < trig_lvl(sel);
  endfunction

  // transmit ready flag, set on becoming ready or on enabling
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_cond_d_reg <= 1'b0;
      thr_flag_reg  <= 1'b0;
    end else begin
      tx_cond_d_reg <= tx_cond;
      thr_flag_reg  <= (tx_cond & ~tx_cond_d_reg)
                     | (wr_ier & host_req.wdata[1] & ~ier_reg[1] & tx_cond)
                     | (thr_flag_reg & ~wr_thr
                        & ~(rd_isr & code == uart_irq_pkg::ISR_THR));
    end
  end

  // line status: overrun at once, head errors when byte reaches the top
  assign head_new = rhr_pop_reg | (rx_stat.level != 5'h00 & ~nonempty_d_reg);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovr_flag_reg   <= 1'b0;
      err_reg        <= 3'h0;
      nonempty_d_reg <= 1'b0;
    end else begin
      nonempty_d_reg <= rx_stat.level != 5'h00;
      ovr_flag_reg   <= rx_stat.overrun | (ovr_flag_reg & ~rd_lsr);
      err_reg <= (head_new ? rx_stat.head_err : 3'h0)
               | (err_reg & ~{3{rd_lsr}});
    end
  end

  // receive timeout: bit times since last fifo activity
  assign char_bits  = 7'h07 + {5'h00, cfg_reg.line_control_reg[1:0]}
                    + {6'h00, cfg_reg.line_control_reg[3]} + {6'h00, cfg_reg.line_control_reg[2]};
  assign tout_limit = 7'((char_bits * uart_irq_pkg::TOUT_CHARS)
                    + uart_irq_pkg::TOUT_BITS);
  assign tout_hit   = bit_tick & tout_cnt_reg == tout_limit - 7'h01;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tout_cnt_reg  <= 7'h00;
      tout_flag_reg <= 1'b0;
    end else begin
      if (rx_stat.char_in | rd_rhr | rx_stat.level == 5'h00)
        tout_cnt_reg <= 7'h00;
      else if (bit_tick && tout_cnt_reg != tout_limit)
        tout_cnt_reg <= tout_cnt_reg + 7'h01;
      tout_flag_reg <= (tout_hit & cfg_reg.fifo_en)
                     | (tout_flag_reg & ~rd_rhr);  // set wins
    end
  end

  // modem pins: three stages, change taken when stages two and three agree
  assign chg = (m2_reg ^ m3_reg) == 4'h0 ? (m3_reg ^ mst_reg) : 4'h0;
  assign cts_rise = chg[0] & m3_reg[0] & cfg_reg.enhanced_feature_control[uart_irq_pkg::EFR_ACTS_BIT];
  assign rts_rise = flow_evt.rts_n & ~rts_d_reg
                  & cfg_reg.enhanced_feature_control[uart_irq_pkg::EFR_ARTS_BIT];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      m1_reg    <= uart_irq_pkg::MODEM_RST;
      m2_reg    <= uart_irq_pkg::MODEM_RST;
      m3_reg    <= uart_irq_pkg::MODEM_RST;
      mst_reg   <= uart_irq_pkg::MODEM_RST;
      delta_reg <= 4'h0;
      rts_d_reg <= 1'b1;
      flow_flag_reg <= 1'b0;
    end else begin
      m1_reg    <= modem_n;
      m2_reg    <= m1_reg;
      m3_reg    <= m2_reg;
      mst_reg   <= mst_reg ^ chg;
      delta_reg <= chg | (delta_reg & ~{4{rd_msr}});
      rts_d_reg <= flow_evt.rts_n;
      flow_flag_reg <= (ier_eff[7] & cts_rise) | (ier_eff[6] & rts_rise)
                     | (flow_flag_reg & ~rd_msr);
    end
  end

  // pause/special character flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xoff_flag_reg <= 1'b0;
      spec_flag_reg <= 1'b0;
    end else begin
      xoff_flag_reg <= flow_evt.xoff | (xoff_flag_reg & ~flow_evt.xon
                     & ~(rd_isr & code == uart_irq_pkg::ISR_XOFF));
      spec_flag_reg <= flow_evt.special | (spec_flag_reg & ~rx_stat.char_in
                     & ~(rd_isr & code == uart_irq_pkg::ISR_XOFF));
    end
  end

  // enabled pending sources, level 1 highest
  assign pend[1] = ier_eff[2] & (ovr_flag_reg | (|err_reg));
  assign pend[2] = ier_eff[0] & tout_flag_reg;
  assign pend[3] = ier_eff[0] & rx_cond;
  assign pend[4] = ier_eff[1] & thr_flag_reg;
  assign pend[5] = ier_eff[3] & (|delta_reg);
  assign pend[6] = ier_eff[5] & (xoff_flag_reg | spec_flag_reg);
  assign pend[7] = (ier_eff[7] | ier_eff[6]) & flow_flag_reg;

  // priority encoder: only the highest source is reported
  always_comb begin
    if (pend[1])      code = uart_irq_pkg::ISR_LSR;
    else if (pend[2]) code = uart_irq_pkg::ISR_TOUT;
    else if (pend[3]) code = uart_irq_pkg::ISR_RXD;
    else if (pend[4]) code = uart_irq_pkg::ISR_THR;
    else if (pend[5]) code = uart_irq_pkg::ISR_MSR;
    else if (pend[6]) code = uart_irq_pkg::ISR_XOFF;
    else if (pend[7]) code = uart_irq_pkg::ISR_FLOW;
    else              code = uart_irq_pkg::ISR_NONE;
  end

  // read data selection per bank
  always_comb begin
    rd_mux = 8'h00;
    if (enh_bank) begin
      case (host_req.addr)
        uart_irq_pkg::A_ISR: rd_mux = cfg_reg.enhanced_feature_control;
        uart_irq_pkg::A_LCR: rd_mux = cfg_reg.line_control_reg;
        3'h4:    rd_mux = cfg_reg.resume_char_first;
        3'h5:    rd_mux = cfg_reg.resume_char_second;
        3'h6:    rd_mux = cfg_reg.pause_char_first;
        3'h7:    rd_mux = cfg_reg.pause_char_second;
        default: rd_mux = 8'h00;
      endcase
    end else begin
      case (host_req.addr)
        uart_irq_pkg::A_DATA: rd_mux = div_bank ? 8'h00 : rx_stat.data;
        uart_irq_pkg::A_IER:  rd_mux = div_bank ? 8'h00 : ier_eff;
        uart_irq_pkg::A_ISR:  rd_mux = (div_bank & efr4) ? {2'h0, dld_reg}
                              : {{2{cfg_reg.fifo_en}}, code};
        uart_irq_pkg::A_LCR:  rd_mux = cfg_reg.line_control_reg;
        uart_irq_pkg::A_MCR:  rd_mux = {ext_reg.mcr_hi, cfg_reg.mcr_lo};
        uart_irq_pkg::A_LSR:  rd_mux = {rx_stat.fifo_err,
                              tx_stat.level == 5'h00 & tx_stat.shift_empty,
                              tx_stat.level == 5'h00, err_reg, ovr_flag_reg,
                              rx_stat.level != 5'h00};
        uart_irq_pkg::A_MSR:  rd_mux = {~mst_reg, delta_reg};
        default:              rd_mux = spr_reg;
      endcase
    end
  end

  // host answer, datapath strobes and interrupt output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_reg       <= 8'h00;
      rhr_pop_reg       <= 1'b0;
      thr_push_reg      <= 1'b0;
      thr_data_reg      <= 8'h00;
      rx_fifo_clear_reg <= 1'b0;
      tx_fifo_clear_reg <= 1'b0;
      irq_reg           <= 1'b0;
    end else begin
      if (rd) rd_data_reg <= rd_mux;
      rhr_pop_reg       <= rd_rhr;
      thr_push_reg      <= wr_thr;
      if (wr_thr) thr_data_reg <= host_req.wdata;
      rx_fifo_clear_reg <= wr_fcr & host_req.wdata[0] & host_req.wdata[1];
      tx_fifo_clear_reg <= wr_fcr & host_req.wdata[0] & host_req.wdata[2];
      irq_reg           <= |pend;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_irq_follows: assert property ((|pend) |=> irq_reg)
    else $error("irq not raised for pending source");
  a_isr_none: assert property (pend == 7'h00 |-> code == 6'h01)
    else $error("idle code wrong");
  a_lsr_clear: assert property (rd_lsr && !rx_stat.overrun |=> !ovr_flag_reg)
    else $error("overrun not cleared by status read");
  a_rx_trigger: assert property (cfg_reg.fifo_en && ier_reg[0]
    && rx_stat.level >= trig_lvl(cfg_reg.rx_trig) && !pend[1] && !pend[2]
    |-> code == uart_irq_pkg::ISR_RXD)
    else $error("rx trigger not reported");
  a_thr_write: assert property (wr_thr && !(tx_cond && !tx_cond_d_reg)
    |=> !thr_flag_reg)
    else $error("tx ready not cleared by write");
  a_thr_enable: assert property (wr_ier && host_req.wdata[1] && !ier_reg[1]
    && tx_cond |=> thr_flag_reg ##0 ier_reg[1])
    else $error("tx ready missing on enable");
  a_tout_read: assert property (rd_rhr && !tout_hit |=> !tout_flag_reg)
    else $error("timeout not cleared by data read");
  a_ier_guard: assert property (wr_ier && !efr4
    |=> ier_reg[7:4] == $past(ier_reg[7:4]))
    else $error("upper enables written without enhanced");
  a_msr_clear: assert property (rd_msr && chg == 4'h0 && !cts_rise && !rts_rise
    |=> delta_reg == 4'h0 && !flow_flag_reg)
    else $error("modem read did not clear");
  a_fifo_bits: assert property (rd_isr
    |=> rd_data_reg[7:6] == {2{$past(cfg_reg.fifo_en)}})
    else $error("fifo bits wrong in status");
  a_data_ready: assert property (rd_lsr
    |=> rd_data_reg[0] == ($past(rx_stat.level) != 5'h00))
    else $error("data ready bit wrong");
  c_tout_seen: cover property (rd_isr && code == uart_irq_pkg::ISR_TOUT);
  c_irq_drop: cover property (irq_reg ##1 !irq_reg);
  c_flow_irq: cover property (pend[7] && code == uart_irq_pkg::ISR_FLOW);
endmodule
`default_nettype wire

/* host_bus_model.sv */
// host processor model driving the parallel register port
// assumes one access at a time, inputs change 1ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  // clock
  input  wire logic                   ref_clk,
  // register port
  output var uart_irq_pkg::host_req_s host_req,
  input  wire logic [7:0]             rd_data_reg
);
  // idle bus at time zero
  initial begin
    host_req = '0;
  end
  // one access held through its taken edge, then released inverted
  task automatic access(input logic r, input logic [2:0] a,
                        input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    host_req = '{cs: 1'b1, rd: r, wr: !r, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    host_req = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask
  // register read, answer taken once it has settled
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    access(1'b1, a, 8'h00);
    @(posedge ref_clk);
    #1;
    d = rd_data_reg;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the uart interrupt/status block
// assumes host_bus_model as the register master, one clock domain
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic                    ref_clk = 1'b0;
  logic                    rst = 1'b1;
  uart_irq_pkg::host_req_s host_req;
  uart_irq_pkg::rx_stat_s  rx = '0;
  uart_irq_pkg::tx_stat_s  tx = '{level: 5'h00, shift_empty: 1'b1};
  uart_irq_pkg::flow_evt_s flow = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic                    bit_tick = 1'b0;
  logic [3:0]              modem_n = 4'hf;
  logic [7:0]              rd_data_reg, thr_data_reg, d, seen;
  logic                    rhr_pop_reg, thr_push_reg, irq_reg;
  logic [31:0]             rnd = 32'h1ac1;
  int                      error_cnt = 0;
  int                      compares = 0;
  int                      n;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  host_bus_model u_host (.ref_clk(ref_clk), .host_req(host_req),
                         .rd_data_reg(rd_data_reg));
  uart_interrupt_enable_status u_dut (
    .ref_clk(ref_clk), .rst(rst), .host_req(host_req),
    .rd_data_reg(rd_data_reg), .rx_stat(rx), .tx_stat(tx),
    .bit_tick(bit_tick), .flow_evt(flow), .modem_n(modem_n),
    .rhr_pop_reg(rhr_pop_reg), .thr_push_reg(thr_push_reg),
    .thr_data_reg(thr_data_reg), .rx_fifo_clear_reg(),
    .tx_fifo_clear_reg(), .cfg_reg(), .ext_reg(), .irq_reg(irq_reg));
  // random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // receive trigger depth per select code
  function automatic logic [4:0] trig(input logic [1:0] sel);
    case (sel)
      2'd0: return 5'h01;
      2'd1: return 5'h04;
      2'd2: return 5'h08;
      default: return 5'h0e;
    endcase
  endfunction
  // status byte with fifos enabled
  function automatic logic [7:0] interrupt_source_status(input logic [5:0] code);
    return {2'b11, code};
  endfunction
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // bounded wait for the interrupt level
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 60; i++) begin
      if (irq_reg === v) return;
      step();
    end
    error_cnt++;
    $display("wrong value irq_reg exp %h got %h", v, irq_reg);
    end_of_test();
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      step();
      bit_tick = 1'b1;
      step();
      bit_tick = 1'b0;
    end
  endtask
  // new receive level with an entry strobe
  task automatic rx_put(input logic [4:0] lvl);
    rnd = lfsr(rnd);
    rx.level = lvl;
    rx.data = rnd[7:0];
    rx.char_in = 1'b1;
    step();
    rx.char_in = 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // reset values
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", 8'h01, d)
    u_host.rd(uart_irq_pkg::A_IER, d); `CHK("ier", 8'h00, d)
    `CHK("irq", 1'b0, irq_reg)
    // upper enables locked until enhanced bit set
    u_host.wr(uart_irq_pkg::A_IER, 8'hf0);
    u_host.rd(uart_irq_pkg::A_IER, d); `CHK("ier", 8'h00, d)
    u_host.wr(uart_irq_pkg::A_LCR, 8'hbf);
    u_host.wr(uart_irq_pkg::A_ISR, 8'h10);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("efr", 8'h10, d)
    u_host.wr(uart_irq_pkg::A_LCR, 8'h00);
    u_host.wr(uart_irq_pkg::A_IER, 8'h20);
    u_host.rd(uart_irq_pkg::A_IER, d); `CHK("ier", 8'h20, d)
    rnd = lfsr(rnd);
    u_host.wr(uart_irq_pkg::A_SPR, rnd[7:0]);
    u_host.rd(uart_irq_pkg::A_SPR, d); `CHK("spr", rnd[7:0], d)
    u_host.wr(uart_irq_pkg::A_ISR, 8'h01);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", 8'hc1, d)
    // pause character match, cleared by status read
    flow.xoff = 1'b1;
    step();
    flow.xoff = 1'b0;
    wait_irq(1'b1);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h10), d)
    wait_irq(1'b0);
    // transmit ready raised at once when already empty
    u_host.wr(uart_irq_pkg::A_IER, 8'h02);
    wait_irq(1'b1);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h02), d)
    wait_irq(1'b0);
    rnd = lfsr(rnd);
    u_host.wr(uart_irq_pkg::A_DATA, rnd[7:0]);
    n = 0;
    for (int i = 0; i < 3; i++) begin
      if (thr_push_reg === 1'b1) begin
        n++;
        seen = thr_data_reg;
      end
      step();
    end
    `CHK("push", 1, n)
    `CHK("thr", rnd[7:0], seen)
    // receive trigger at every select code, one below then at level
    u_host.wr(uart_irq_pkg::A_IER, 8'h01);
    for (int s = 0; s < 4; s++) begin
      u_host.wr(uart_irq_pkg::A_ISR, {s[1:0], 6'h01});
      rx_put(trig(s[1:0]) - 5'h01);
      u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", 8'hc1, d)
      rx_put(trig(s[1:0]));
      wait_irq(1'b1);
      u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h04), d)
      u_host.rd(uart_irq_pkg::A_LSR, d); `CHK("lsr", 8'h61, d)
      rx.level = trig(s[1:0]) - 5'h01;
      wait_irq(1'b0);
    end
    // overrun outranks receive data, line status read clears it
    u_host.wr(uart_irq_pkg::A_IER, 8'h05);
    rx_put(5'h0e);
    rx.overrun = 1'b1;
    step();
    rx.overrun = 1'b0;
    repeat (3) step();
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h06), d)
    u_host.rd(uart_irq_pkg::A_LSR, d); `CHK("lsr", 8'h63, d)
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h04), d)
    // receive timeout: 4 x 7 bit frames plus 12 bits = 40 ticks
    u_host.wr(uart_irq_pkg::A_IER, 8'h01);
    rx.level = 5'h00;
    step();
    rx_put(5'h01);
    ticks(38);
    `CHK("irq", 1'b0, irq_reg)
    ticks(4);
    wait_irq(1'b1);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h0c), d)
    u_host.rd(uart_irq_pkg::A_DATA, d);
    wait_irq(1'b0);
    // modem delta on cts pin, cleared by modem status read
    u_host.wr(uart_irq_pkg::A_IER, 8'h08);
    modem_n[0] = 1'b0;
    wait_irq(1'b1);
    u_host.rd(uart_irq_pkg::A_ISR, d); `CHK("isr", interrupt_source_status(6'h00), d)
    u_host.rd(uart_irq_pkg::A_MSR, d); `CHK("msr", 8'h11, d)
    wait_irq(1'b0);
    // polled mode: status visible, no interrupt
    u_host.wr(uart_irq_pkg::A_IER, 8'h00);
    rx_put(5'h0e);
    repeat (4) step();
    `CHK("irq", 1'b0, irq_reg)
    u_host.rd(uart_irq_pkg::A_LSR, d); `CHK("lsr", 8'h61, d)
    end_of_test();
  end
endmodule
`default_nettype wire
